// ### logic/gpe_port.sv
// gpio edge port: two-pin interrupt port and eight-pin data port registers
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "gpe_map.svh"
module gpe_port (
  input  wire logic                   i_clk,
  input  wire logic                   i_srst,
  input  wire logic [`GPE_ADDR_W-1:0] i_addr,
  input  wire logic [`GPE_DATA_W-1:0] i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [`GPE_DATA_W-1:0] o_rdata,
  output logic                        o_irq,
  input  wire logic [`GPE_J_W-1:0]    i_j_pin,
  input  wire logic [`GPE_J_W-1:0]    i_j_is_output,
  input  wire logic [`GPE_J_W-1:0]    i_j_wired_or,
  output logic      [`GPE_J_W-1:0]    o_j_drive_reduced,
  output logic      [`GPE_J_W-1:0]    o_j_pull_up,
  output logic      [`GPE_J_W-1:0]    o_j_pull_down,
  input  wire logic [`GPE_AD_W-1:0]   i_ad_pin,
  input  wire logic [`GPE_AD_W-1:0]   i_ad_periph_en,
  input  wire logic [`GPE_AD_W-1:0]   i_ad_periph_dir,
  input  wire logic [`GPE_AD_W-1:0]   i_ad_periph_out,
  output logic      [`GPE_AD_W-1:0]   o_ad_out,
  output logic      [`GPE_AD_W-1:0]   o_ad_oe_n
);

  gpe_pkg::gpe_state_t st_r;
  gpe_pkg::gpe_state_t st_nxt;

  gpe_pkg::gpe_j_t  j_sync;
  gpe_pkg::gpe_j_t  j_edge;
  gpe_pkg::gpe_ad_t ad_sync;
  gpe_pkg::gpe_ad_t ad_eff_dir;
  gpe_pkg::gpe_ad_t ad_eff_out;
  gpe_pkg::gpe_ad_t ad_read_mux;
  gpe_pkg::gpe_j_t  flag_clr;
  gpe_pkg::gpe_j_t  j_pull_act;
  logic             wr_hit_flag;

  //////////////////////////////////////////////////////////////////////////////
  // input synchronisers and edge detection

  gpe_sync #(
    .W (`GPE_J_W)
  ) u_sync_j (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_async (i_j_pin),
    .o_sync  (j_sync)
  );

  gpe_sync #(
    .W (`GPE_AD_W)
  ) u_sync_ad (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_async (i_ad_pin),
    .o_sync  (ad_sync)
  );

  gpe_edge #(
    .W (`GPE_J_W)
  ) u_edge_j (
    .i_clk    (i_clk),
    .i_srst   (i_srst),
    .i_level  (j_sync),
    .i_rising (st_r.pol),
    .o_edge   (j_edge)
  );

  //////////////////////////////////////////////////////////////////////////////
  // combinational helpers

  assign ad_eff_dir = (i_ad_periph_en & i_ad_periph_dir) | (~i_ad_periph_en & st_r.ad_dir);
  assign ad_eff_out = (i_ad_periph_en & i_ad_periph_out) | (~i_ad_periph_en & st_r.ad_data);

  // stored value for outputs, pin for inputs
  assign ad_read_mux = (st_r.ad_data & st_r.ad_dir) | (ad_sync & ~st_r.ad_dir);

  assign wr_hit_flag = i_wr && (i_addr == `GPE_OFF_J_FLAG);
  assign flag_clr    = wr_hit_flag ? i_wdata[`GPE_J_MSB:`GPE_J_LSB] : `GPE_RST_J;

  // pull only for inputs or wired-or
  assign j_pull_act = st_r.pull & (~i_j_is_output | i_j_wired_or);

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_nxt = st_r;

    if (i_wr) begin
      unique case (i_addr)
        `GPE_OFF_J_DRIVE: begin
          st_nxt.drive = i_wdata[`GPE_J_MSB:`GPE_J_LSB];
        end
        `GPE_OFF_J_PULL: begin
          st_nxt.pull = i_wdata[`GPE_J_MSB:`GPE_J_LSB];
        end
        `GPE_OFF_J_POL: begin
          st_nxt.pol = i_wdata[`GPE_J_MSB:`GPE_J_LSB];
        end
        `GPE_OFF_J_IEN: begin
          st_nxt.ien = i_wdata[`GPE_J_MSB:`GPE_J_LSB];
        end
        `GPE_OFF_AD_DATA: begin
          st_nxt.ad_data = i_wdata;
        end
        `GPE_OFF_AD_DIR: begin
          st_nxt.ad_dir = i_wdata;
        end
        default: begin
        end
      endcase
    end

    st_nxt.flag = (st_r.flag & ~flag_clr) | j_edge;

    st_nxt.irq = |(st_nxt.flag & st_nxt.ien);

    // read data stand only in the cycle after the strobe
    st_nxt.rdata = `GPE_RST_RDATA;
    if (i_rd) begin
      unique case (i_addr)
        `GPE_OFF_J_DRIVE: begin
          st_nxt.rdata = {st_r.drive, `GPE_J_LOW_ZERO};
        end
        `GPE_OFF_J_PULL: begin
          st_nxt.rdata = {st_r.pull, `GPE_J_LOW_ZERO};
        end
        `GPE_OFF_J_POL: begin
          st_nxt.rdata = {st_r.pol, `GPE_J_LOW_ZERO};
        end
        `GPE_OFF_J_IEN: begin
          st_nxt.rdata = {st_r.ien, `GPE_J_LOW_ZERO};
        end
        `GPE_OFF_J_FLAG: begin
          st_nxt.rdata = {st_r.flag, `GPE_J_LOW_ZERO};
        end
        `GPE_OFF_AD_DATA: begin
          st_nxt.rdata = ad_read_mux;
        end
        `GPE_OFF_AD_PIN: begin
          st_nxt.rdata = ad_sync;
        end
        `GPE_OFF_AD_DIR: begin
          st_nxt.rdata = st_r.ad_dir;
        end
        default: begin
          st_nxt.rdata = `GPE_RST_RDATA;
        end
      endcase
    end

    st_nxt.j_drv_red = st_r.drive & i_j_is_output;
    // pull-up for polarity 0, also on wired-or outputs
    st_nxt.j_pull_up = j_pull_act & ~st_r.pol;
    // pull-down for polarity 1, inputs only
    st_nxt.j_pull_dn = j_pull_act & st_r.pol & ~i_j_is_output;

    st_nxt.ad_out  = ad_eff_out;
    st_nxt.ad_oe_n = ~ad_eff_dir;
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_r.drive     <= `GPE_RST_J;
      st_r.pull      <= `GPE_RST_J;
      st_r.pol       <= `GPE_RST_J;
      st_r.ien       <= `GPE_RST_J;
      st_r.flag      <= `GPE_RST_J;
      st_r.ad_data   <= `GPE_RST_AD;
      st_r.ad_dir    <= `GPE_RST_AD;
      st_r.rdata     <= `GPE_RST_RDATA;
      st_r.irq       <= 1'b0;
      st_r.j_drv_red <= `GPE_RST_J;
      st_r.j_pull_up <= `GPE_RST_J;
      st_r.j_pull_dn <= `GPE_RST_J;
      st_r.ad_out    <= `GPE_RST_AD;
      st_r.ad_oe_n   <= `GPE_OE_IDLE_AD;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_rdata           = st_r.rdata;
  assign o_irq             = st_r.irq;
  assign o_j_drive_reduced = st_r.j_drv_red;
  assign o_j_pull_up       = st_r.j_pull_up;
  assign o_j_pull_down     = st_r.j_pull_dn;
  assign o_ad_out          = st_r.ad_out;
  assign o_ad_oe_n         = st_r.ad_oe_n;

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  sequence s_rd_addr(logic [`GPE_ADDR_W-1:0] a);
    i_rd && (i_addr == a);
  endsequence

  sequence s_wr_addr(logic [`GPE_ADDR_W-1:0] a);
    i_wr && (i_addr == a);
  endsequence

  a_edge_sets_flag: assert property (
    (j_edge != `GPE_RST_J) |=> ((st_r.flag & $past(j_edge)) == $past(j_edge)))
    else $error("active edge did not set its flag");

  a_flag_w1c: assert property (
    (s_wr_addr(`GPE_OFF_J_FLAG) ##0 (j_edge == `GPE_RST_J))
    |=> ((st_r.flag & $past(i_wdata[`GPE_J_MSB:`GPE_J_LSB])) == `GPE_RST_J))
    else $error("writing one did not clear flag");

  // a coinciding edge may legally set a bit, so it is left out
  a_flag_w0_keep: assert property (
    (s_wr_addr(`GPE_OFF_J_FLAG) ##0 (j_edge == `GPE_RST_J))
    |=> ((st_r.flag & ~$past(i_wdata[`GPE_J_MSB:`GPE_J_LSB])) ==
         ($past(st_r.flag) & ~$past(i_wdata[`GPE_J_MSB:`GPE_J_LSB]))))
    else $error("writing zero changed a flag");

  a_irq_masking: assert property (
    o_irq == |(st_r.flag & st_r.ien))
    else $error("interrupt does not follow flag and enable");

  a_irq_disabled: assert property (
    (st_r.ien == `GPE_RST_J) |-> !o_irq)
    else $error("interrupt raised while all enables clear");

  a_data_read_mux: assert property (
    s_rd_addr(`GPE_OFF_AD_DATA) |=> (o_rdata == $past(ad_read_mux)) ##1
    (o_rdata == `GPE_RST_RDATA || $past(i_rd)))
    else $error("data read returned wrong mix");

  a_pin_read_live: assert property (
    s_rd_addr(`GPE_OFF_AD_PIN) |=> (o_rdata == $past(i_ad_pin, 3)))
    else $error("pin-input read not the synchronised level");

  a_pin_write_ignored: assert property (
    s_wr_addr(`GPE_OFF_AD_PIN) |=> $stable(st_r.ad_data) && $stable(st_r.ad_dir))
    else $error("write to pin-input register had effect");

  a_dir_to_oe: assert property (
    (i_ad_periph_en == `GPE_RST_AD) |=> (o_ad_oe_n == ~$past(st_r.ad_dir)))
    else $error("output enable does not follow direction");

  a_periph_override: assert property (
    1'b1 |=> (o_ad_oe_n == ~$past(ad_eff_dir)) && (o_ad_out == $past(ad_eff_out)))
    else $error("peripheral control not applied");

  a_sync_depth: assert property (
    ##2 (ad_sync == $past(i_ad_pin, 2)))
    else $error("synchroniser depth is not two");

  a_drive_gated: assert property (
    1'b1 |=> ((o_j_drive_reduced & ~$past(i_j_is_output)) == `GPE_RST_J))
    else $error("reduced drive shown on an input pin");

  a_pull_gated: assert property (
    1'b1 |=> (((o_j_pull_up | o_j_pull_down) &
              $past(i_j_is_output) & ~$past(i_j_wired_or)) == `GPE_RST_J))
    else $error("pull active on push-pull output");

  a_pull_polarity: assert property (
    1'b1 |=> ((o_j_pull_down & ~$past(st_r.pol)) == `GPE_RST_J) &&
             ((o_j_pull_up & $past(st_r.pol)) == `GPE_RST_J))
    else $error("pull direction disagrees with polarity");

  a_unimpl_zero: assert property (
    (s_rd_addr(`GPE_OFF_J_DRIVE) or s_rd_addr(`GPE_OFF_J_FLAG))
    |=> (o_rdata[`GPE_J_LOW_MSB:0] == `GPE_J_LOW_ZERO))
    else $error("unimplemented bits read non-zero");

  a_data_store: assert property (
    s_wr_addr(`GPE_OFF_AD_DATA) |=> (st_r.ad_data == $past(i_wdata)))
    else $error("data write not stored");

  a_flag_hold: assert property (
    (!wr_hit_flag && (j_edge == `GPE_RST_J)) |=> $stable(st_r.flag))
    else $error("flag changed with no edge and no clear");

  a_flag_no_spurious: assert property (
    1'b1 |=> ((st_r.flag & ~$past(st_r.flag) & ~$past(j_edge)) == `GPE_RST_J))
    else $error("flag set without an active edge");

  a_ien_store: assert property (
    s_wr_addr(`GPE_OFF_J_IEN) |=> (st_r.ien == $past(i_wdata[`GPE_J_MSB:`GPE_J_LSB])))
    else $error("interrupt enable write not stored");

  a_pol_store: assert property (
    s_wr_addr(`GPE_OFF_J_POL) |=> (st_r.pol == $past(i_wdata[`GPE_J_MSB:`GPE_J_LSB])))
    else $error("polarity write not stored");

  a_dir_store: assert property (
    s_wr_addr(`GPE_OFF_AD_DIR) |=> (st_r.ad_dir == $past(i_wdata)))
    else $error("direction write not stored");

  a_drive_follow: assert property (
    1'b1 |=> (o_j_drive_reduced == ($past(st_r.drive) & $past(i_j_is_output))))
    else $error("reduced drive does not follow its bit");

endmodule : gpe_port
`default_nettype wire

// ### logic/gpe_map.svh
// register offsets, field positions and reset values of the gpio edge port block
`ifndef GPE_MAP_SVH
`define GPE_MAP_SVH

`define GPE_ADDR_W       8
`define GPE_DATA_W       8
`define GPE_J_W          2
`define GPE_AD_W         8
`define GPE_J_MSB        7
`define GPE_J_LSB        6
`define GPE_J_LOW_MSB    5

`define GPE_OFF_J_DRIVE  8'h2b
`define GPE_OFF_J_PULL   8'h2c
`define GPE_OFF_J_POL    8'h2d
`define GPE_OFF_J_IEN    8'h2e
`define GPE_OFF_J_FLAG   8'h2f
`define GPE_OFF_AD_DATA  8'h30
`define GPE_OFF_AD_PIN   8'h31
`define GPE_OFF_AD_DIR   8'h32

`define GPE_RST_J        2'h0
`define GPE_RST_AD       8'h00
`define GPE_RST_RDATA    8'h00
`define GPE_OE_IDLE_AD   8'hff
`define GPE_J_LOW_ZERO   6'h00

`endif

// ### logic/gpe_pkg.sv
// types shared by the gpio edge port block
`default_nettype none
`include "gpe_map.svh"
package gpe_pkg;

  typedef logic [`GPE_J_W-1:0]  gpe_j_t;
  typedef logic [`GPE_AD_W-1:0] gpe_ad_t;

  typedef struct packed {
    gpe_j_t  drive;
    gpe_j_t  pull;
    gpe_j_t  pol;
    gpe_j_t  ien;
    gpe_j_t  flag;
    gpe_ad_t ad_data;
    gpe_ad_t ad_dir;
    logic [`GPE_DATA_W-1:0] rdata;
    logic    irq;
    gpe_j_t  j_drv_red;
    gpe_j_t  j_pull_up;
    gpe_j_t  j_pull_dn;
    gpe_ad_t ad_out;
    gpe_ad_t ad_oe_n;
  } gpe_state_t;

endpackage : gpe_pkg
`default_nettype wire

// ### logic/gpe_sync.sv
// two-stage input synchroniser, one stage pair per bit
`timescale 1ns/1ps
`default_nettype none
module gpe_sync #(
  parameter int W = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } gpe_sync_st_t;

  gpe_sync_st_t st_r;
  gpe_sync_st_t st_nxt;

  // first stage feeds only the second stage
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = i_async;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_sync = st_r.s2;

endmodule : gpe_sync
`default_nettype wire

// ### logic/gpe_edge.sv
// per-pin edge detector with selectable active edge
`timescale 1ns/1ps
`default_nettype none
module gpe_edge #(
  parameter int W = 2
) (
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  input  wire logic [W-1:0] i_level,
  input  wire logic [W-1:0] i_rising,
  output logic      [W-1:0] o_edge
);

  typedef struct packed {
    logic [W-1:0] prev;
  } gpe_edge_st_t;

  gpe_edge_st_t st_r;
  gpe_edge_st_t st_nxt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.prev = i_level;
  end

  // reset loads the present level so release makes no false edge
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_r.prev <= i_level;
    end else begin
      st_r <= st_nxt;
    end
  end

  for (genvar k = 0; k < W; k++) begin : g_pin
    assign o_edge[k] = i_rising[k] ? (i_level[k] & ~st_r.prev[k])
                                   : (~i_level[k] & st_r.prev[k]);
  end

endmodule : gpe_edge
`default_nettype wire

// ### testbench/gpe_pins_model.sv
// pin-side model: package pads of the eight-pin and two-pin ports
`timescale 1ns/1ps
`default_nettype none
module gpe_pins_model (
  input  wire logic [7:0] i_ad_ext,
  input  wire logic [7:0] i_ad_out,
  input  wire logic [7:0] i_ad_oe_n,
  input  wire logic [1:0] i_j_ext,
  output logic      [7:0] o_ad_pin,
  output logic      [1:0] o_j_pin
);
  ////////////////////////////////////////////////////////////////////////////
  // pad resolution
  // a driven pad shows the block's value, an undriven one the outside level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      o_ad_pin[i] = i_ad_oe_n[i] ? i_ad_ext[i] : i_ad_out[i];
    end
  end
  assign o_j_pin = i_j_ext;
endmodule : gpe_pins_model
`default_nettype wire

// ### testbench/tb_gpe_port.sv
// self-checking bench for the gpio edge port block
`timescale 1ns/1ps
`default_nettype none
`include "gpe_map.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  $display("mismatch %s expected %h seen %h", nm, e, g); n_fail++; end end
module tb_gpe_port;
  logic       i_clk, i_srst, i_wr, i_rd;
  logic [7:0] i_addr, i_wdata, o_rdata, o_ad_out, o_ad_oe_n, ad_pin, ad_ext;
  logic [7:0] per_en, per_dir, per_out;
  logic [1:0] j_pin, j_ext, j_is_out, j_wor, o_j_red, o_j_pu, o_j_pd;
  logic       o_irq;
  int         n_fail, n_checks, cycles;

  gpe_port gpe_port_inst (
    .i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
    .i_j_pin(j_pin), .i_j_is_output(j_is_out), .i_j_wired_or(j_wor),
    .o_j_drive_reduced(o_j_red), .o_j_pull_up(o_j_pu), .o_j_pull_down(o_j_pd),
    .i_ad_pin(ad_pin), .i_ad_periph_en(per_en), .i_ad_periph_dir(per_dir),
    .i_ad_periph_out(per_out), .o_ad_out(o_ad_out), .o_ad_oe_n(o_ad_oe_n));

  gpe_pins_model gpe_pins_model_inst (
    .i_ad_ext(ad_ext), .i_ad_out(o_ad_out), .i_ad_oe_n(o_ad_oe_n),
    .i_j_ext(j_ext), .o_ad_pin(ad_pin), .o_j_pin(j_pin));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    cycles++;
    // generous ceiling: the sequence needs about 130 cycles
    if (cycles == 5000) begin
      n_fail++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  // read data only stand in the cycle after the strobe, so look there
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    `CHK(nm, e, o_rdata)
  endtask : rd_chk

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_srst = 1'b1; i_wr = 1'b0; i_rd = 1'b0; i_addr = 8'h00; i_wdata = 8'h00;
    ad_ext = 8'h00; j_ext = 2'h2; j_is_out = 2'h0; j_wor = 2'h0;
    per_en = 8'h00; per_dir = 8'h00; per_out = 8'h00;
    n_fail = 0; n_checks = 0; cycles = 0;
    repeat (12) @(posedge i_clk);
    i_srst <= 1'b0;
    cyc(1);
    `CHK("oe_n rst", 8'hff, o_ad_oe_n)
    for (int a = 8'h2a; a <= 8'h33; a++) rd_chk("rst", a[7:0], 8'h00);
    for (int a = 8'h2b; a <= 8'h2e; a++) begin
      wr(a[7:0], 8'hff);
      rd_chk("j field", a[7:0], 8'hc0);
      wr(a[7:0], 8'h00);
    end
    // pin6 rising, pin7 falling; both move at once, masked first
    wr(`GPE_OFF_J_POL, 8'h40);
    @(posedge i_clk) j_ext <= 2'h1;
    cyc(5);
    rd_chk("flags", `GPE_OFF_J_FLAG, 8'hc0);
    `CHK("irq masked", 1'b0, o_irq)
    wr(`GPE_OFF_J_IEN, 8'h80);
    cyc(2);
    `CHK("irq on", 1'b1, o_irq)
    wr(`GPE_OFF_J_FLAG, 8'h80);
    cyc(2);
    `CHK("irq cleared", 1'b0, o_irq)
    wr(`GPE_OFF_J_FLAG, 8'h00);
    rd_chk("w0 keeps", `GPE_OFF_J_FLAG, 8'h40);
    // opposite edges on both pins must not set anything
    @(posedge i_clk) j_ext <= 2'h2;
    cyc(5);
    rd_chk("wrong edge", `GPE_OFF_J_FLAG, 8'h40);
    wr(`GPE_OFF_J_FLAG, 8'h40);
    rd_chk("all clear", `GPE_OFF_J_FLAG, 8'h00);
    // pulls and drive strength
    wr(`GPE_OFF_J_PULL, 8'hc0);
    cyc(2);
    `CHK("pu in", 2'h2, o_j_pu)
    `CHK("pd in", 2'h1, o_j_pd)
    @(posedge i_clk) begin
      j_is_out <= 2'h3;
      j_wor    <= 2'h2;
    end
    cyc(2);
    `CHK("pu out", 2'h2, o_j_pu)
    `CHK("pd out", 2'h0, o_j_pd)
    wr(`GPE_OFF_J_DRIVE, 8'hc0);
    @(posedge i_clk) j_is_out <= 2'h1;
    cyc(2);
    `CHK("drive", 2'h1, o_j_red)
    // eight-pin port: low nibble out, high nibble in
    wr(`GPE_OFF_AD_DATA, 8'ha5);
    @(posedge i_clk) ad_ext <= 8'h3c;
    wr(`GPE_OFF_AD_DIR, 8'h0f);
    cyc(3);
    `CHK("oe_n", 8'hf0, o_ad_oe_n)
    `CHK("out", 8'ha5, o_ad_out)
    rd_chk("data mix", `GPE_OFF_AD_DATA, 8'h35);
    rd_chk("pin in", `GPE_OFF_AD_PIN, 8'h35);
    wr(`GPE_OFF_AD_PIN, 8'hff);
    rd_chk("pin ro", `GPE_OFF_AD_PIN, 8'h35);
    rd_chk("dir", `GPE_OFF_AD_DIR, 8'h0f);
    // peripheral takes pin 7 as output, pin 0 as input
    @(posedge i_clk) begin
      per_en  <= 8'h81;
      per_dir <= 8'h80;
      per_out <= 8'h00;
    end
    cyc(2);
    `CHK("per oe_n", 8'h71, o_ad_oe_n)
    `CHK("per out", 8'h24, o_ad_out)
    rd_chk("per dir", `GPE_OFF_AD_DIR, 8'h0f);
    give_verdict();
  end
endmodule : tb_gpe_port
`default_nettype wire
